//--- core/lpmd_pkg.sv
// Constants and types for the phase-matched clock divider
package lpmd_pkg;
  localparam int LPMD_SYNC_STAGES = 2;
  localparam int LPMD_DIV_BITS = 3;
  localparam logic [2:0] LPMD_CNT_RESET = 3'h0;
  localparam logic LPMD_MODE_DEFAULT = 1'b0;
  localparam logic LPMD_GATE_DEFAULT = 1'b0;
  localparam real LPMD_CLK_PERIOD_NS = 10.0;
  typedef enum logic {LPMD_SYNC_CLOCK_A, LPMD_SYNC_CLOCK_B} lpmd_sync_sel_e;
endpackage

//--- core/lpmd_phase_matched_divider.sv
// Phase-matched divider: pass-through and divide-by-2/4/8 copies of clock A
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// [R1] Mode parameter, default off, enables divider
// [R2] Divider-mode instance offers no synthesizer outputs
// [R3] Only clocks A and B are accepted
// [R4] A on primary input, B on feedback
// [R5] Reset forces all outputs low immediately
// [R6] Reset release waits for synchronizing clock edge
// [R7] Release synchronizes to A by default, else B
// [R8] Gate option holds divided outputs until release
// [R9] Release starts divided outputs on A edge
// [R10] Pass-through of A and copy of B
// [R11] Divide by 2,4,8, edges aligned to A
module lpmd_phase_matched_divider
  import lpmd_pkg::*;
#(
  parameter logic divider_mode_select = LPMD_MODE_DEFAULT,
  parameter logic release_gate_enable = LPMD_GATE_DEFAULT,
  parameter lpmd_sync_sel_e reset_release_clock_select = LPMD_SYNC_CLOCK_A
) (
  input wire logic ref_clk_in, // Sampling clock, 100 MHz
  input wire logic reset_n_in, // Synchronous reset, active low
  input wire logic primary_clock_input_in, // Clock A
  input wire logic feedback_clock_input_in, // Clock B
  input wire logic divider_reset_in, // Divider reset, active high, async assert
  input wire logic divided_output_release_in, // Release of divided outputs
  output logic clock_a_passthrough_out, // Undivided copy of A
  output logic clock_a_half_out, // A divided by 2
  output logic clock_a_quarter_out, // A divided by 4
  output logic clock_a_eighth_out, // A divided by 8
  output logic feedback_clock_output_out // Copy of B
);

  // Step counter width is tied to the three divided outputs
  if (LPMD_DIV_BITS != 3) begin : g_bad_width
    $error("lpmd: divider width must be 3");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers; third stage only feeds edge detection
  // Clock inputs are treated as data: phases shorter than one
  // sampling cycle can be lost, a limit the fabric must respect
  logic a_s1_r, a_s2_r, a_s3_r;
  logic b_s1_r, b_s2_r, b_s3_r;
  logic rel_s1_r, rel_s2_r;
  logic rst_s1_r, rst_s2_r;

  always_ff @(posedge ref_clk_in) begin
    a_s1_r <= primary_clock_input_in; // R4
    a_s2_r <= a_s1_r;
    a_s3_r <= a_s2_r;
    b_s1_r <= feedback_clock_input_in; // R4
    b_s2_r <= b_s1_r;
    b_s3_r <= b_s2_r;
    rel_s1_r <= divided_output_release_in;
    rel_s2_r <= rel_s1_r;
  end

  // Reset pin sets the chain at once; clears through two stages
  always_ff @(posedge ref_clk_in or posedge divider_reset_in) begin
    if (divider_reset_in) begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= 1'b1;
    end else begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= rst_s1_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Edge detection and control decode
  wire a_rise = a_s2_r & ~a_s3_r;
  wire b_rise = b_s2_r & ~b_s3_r;
  wire sel_rise = (reset_release_clock_select == LPMD_SYNC_CLOCK_B) ? b_rise : a_rise; // R7
  logic run_r;
  logic released_r;
  logic [LPMD_DIV_BITS-1:0] cnt_r;
  wire run_nxt = run_r | (~rst_s2_r & sel_rise & divider_mode_select); // R6 R1
  wire gate_open = ~release_gate_enable | (rel_s2_r & a_rise); // R8 R9
  wire released_nxt = released_r | (run_r & gate_open);
  wire div_step = run_r & released_r & a_rise; // R11
  wire [LPMD_DIV_BITS-1:0] cnt_nxt = div_step ? cnt_r + 3'h1 : cnt_r;

  //////////////////////////////////////////////////////////////////////////////
  // State flops; divider reset clears them without a clock
  wire hold_div = ~(run_r & released_r);
  wire pass_nxt = run_r & a_s2_r;
  wire fb_nxt = run_r & b_s2_r;
  wire [LPMD_DIV_BITS-1:0] div_w;

  always_ff @(posedge ref_clk_in or posedge divider_reset_in) begin
    if (divider_reset_in) begin // R5
      run_r <= 1'b0;
      released_r <= 1'b0;
      cnt_r <= LPMD_CNT_RESET;
    end else if (!reset_n_in) begin
      run_r <= 1'b0;
      released_r <= 1'b0;
      cnt_r <= LPMD_CNT_RESET;
    end else begin
      run_r <= run_nxt;
      released_r <= released_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Copies of A and B; gated by run so they stay low until sync release
  always_ff @(posedge ref_clk_in or posedge divider_reset_in) begin
    if (divider_reset_in) begin // R5
      clock_a_passthrough_out <= 1'b0;
      feedback_clock_output_out <= 1'b0;
    end else if (!reset_n_in) begin
      clock_a_passthrough_out <= 1'b0;
      feedback_clock_output_out <= 1'b0;
    end else begin
      // Only the two clocks exist here; no synthesizer path is built
      clock_a_passthrough_out <= pass_nxt; // R10 R2 R3
      feedback_clock_output_out <= fb_nxt; // R10
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // One flop per divided output; count bit n gives A over 2 to the n+1
  // Changing only on detected A rises keeps every edge on a copy edge
  genvar gi;
  for (gi = 0; gi < LPMD_DIV_BITS; gi++) begin : g_div
    logic bit_r;
    wire bit_nxt = div_step ? ~cnt_r[gi] : (hold_div ? 1'b0 : bit_r); // R11
    always_ff @(posedge ref_clk_in or posedge divider_reset_in) begin
      if (divider_reset_in) begin // R5
        bit_r <= 1'b0;
      end else if (!reset_n_in) begin
        bit_r <= 1'b0;
      end else begin
        bit_r <= bit_nxt;
      end
    end
    assign div_w[gi] = bit_r;
  end
  assign clock_a_half_out = div_w[0]; // R11
  assign clock_a_quarter_out = div_w[1];
  assign clock_a_eighth_out = div_w[2];

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_release_edge;
    !run_r ##1 run_r;
  endsequence

  chk_mode_off_quiet: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // R1
    !divider_mode_select |-> !run_r)
    else $error("run set with divider mode off");
  chk_reset_low_now: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // R5
    divider_reset_in |-> !clock_a_passthrough_out && !clock_a_half_out && !feedback_clock_output_out
    && !clock_a_quarter_out && !clock_a_eighth_out)
    else $error("output high during divider reset");
  chk_release_on_edge: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in || divider_reset_in) // R6
    s_release_edge |-> $past(sel_rise) && !$past(rst_s2_r))
    else $error("reset released without sync edge");
  chk_sync_select: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // R7
    $rose(run_r) |-> $past((reset_release_clock_select == LPMD_SYNC_CLOCK_B) ?
    (b_s2_r && !b_s3_r) : (a_s2_r && !a_s3_r)))
    else $error("wrong sync clock");
  chk_gate_hold: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in || divider_reset_in) // R8
    (release_gate_enable && !released_r) |-> !clock_a_half_out && !clock_a_eighth_out)
    else $error("divided output before release");
  chk_release_a_sync: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in || divider_reset_in) // R9
    (release_gate_enable && $rose(released_r)) |-> $past(a_rise) && $past(rel_s2_r))
    else $error("release not on clock A edge");
  chk_pass_copy: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in || divider_reset_in) // R10
    run_r ##1 run_r |-> clock_a_passthrough_out == $past(a_s2_r) && feedback_clock_output_out == $past(b_s2_r))
    else $error("pass-through mismatch");
  chk_div_aligned: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in || divider_reset_in) // R11
    $rose(clock_a_half_out) || $rose(clock_a_quarter_out) || $rose(clock_a_eighth_out)
    |-> $rose(clock_a_passthrough_out))
    else $error("divided edge not aligned");
  chk_half_toggles: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in || divider_reset_in) // R11
    div_step && released_r ##1 1 |-> clock_a_half_out == ~$past(cnt_r[0]))
    else $error("half divider wrong");

  //////////////////////////////////////////////////////////////////////////////
  // Divider sequence checks
  sequence s_div_step_done;
    div_step ##1 1;
  endsequence

  chk_quarter_toggles: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in || divider_reset_in) // R11
    s_div_step_done |-> clock_a_quarter_out == ~$past(cnt_r[1]))
    else $error("quarter divider wrong");
  chk_eighth_toggles: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in || divider_reset_in) // R11
    s_div_step_done |-> clock_a_eighth_out == ~$past(cnt_r[2]))
    else $error("eighth divider wrong");
  chk_first_step: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in || divider_reset_in) // R11
    div_step && cnt_r == LPMD_CNT_RESET |=> clock_a_half_out && clock_a_quarter_out && clock_a_eighth_out)
    else $error("divided outputs not rising together");
  chk_div_hold: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in || divider_reset_in) // R11
    run_r && released_r && !div_step |=> $stable(clock_a_half_out) && $stable(clock_a_quarter_out)
    && $stable(clock_a_eighth_out))
    else $error("divided output moved between A rises");
  chk_cnt_steady: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in || divider_reset_in) // R11
    !div_step |=> $stable(cnt_r))
    else $error("step count moved without A rise");

  //////////////////////////////////////////////////////////////////////////////
  // Reset, mode and release checks
  chk_sync_clear: assert property (@(posedge ref_clk_in) // R5
    !reset_n_in |=> !clock_a_passthrough_out && !clock_a_half_out && !clock_a_quarter_out
    && !clock_a_eighth_out && !feedback_clock_output_out)
    else $error("output high after house reset");
  chk_run_sticky: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in || divider_reset_in) // R6
    run_r |=> run_r)
    else $error("run dropped without reset");
  chk_mode_off_low: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // R1
    !divider_mode_select |-> !clock_a_passthrough_out && !feedback_clock_output_out && !clock_a_half_out)
    else $error("output active with divider mode off");
  chk_gate_open: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in || divider_reset_in) // R8
    !release_gate_enable && $rose(run_r) |=> released_r)
    else $error("ungated outputs not released");
  chk_release_needs_run: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // R8
    released_r |-> run_r)
    else $error("released before reset release");
  chk_release_sticky: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in || divider_reset_in) // R9
    released_r |=> released_r)
    else $error("release dropped without reset");

endmodule

//--- sim/lpmd_fabric_model.sv
// Fabric-side model: clock A and B sources that stand still when idle
`timescale 1ns/100ps
module lpmd_fabric_model (
  input wire logic ref_clk_in, // Bench clock
  input wire logic run_in, // Clocks run while high
  output logic clk_a_out, // Clock A, half period 3 cycles
  output logic clk_b_out // Clock B, half period 5 cycles
);
  logic [2:0] na_r = 3'h0;
  logic [2:0] nb_r = 3'h0;
  initial {clk_a_out, clk_b_out} = 2'h0;
  // Only plain clocks are fed in, nothing expects synthesis
  always @(posedge ref_clk_in) begin
    na_r <= (!run_in || na_r == 3'h2) ? 3'h0 : na_r + 3'h1;
    nb_r <= (!run_in || nb_r == 3'h4) ? 3'h0 : nb_r + 3'h1;
    clk_a_out <= run_in && (clk_a_out ^ (na_r == 3'h2));
    clk_b_out <= run_in && (clk_b_out ^ (nb_r == 3'h4));
  end
endmodule

//--- sim/lpmd_phase_matched_divider_tb.sv
// Bench for the phase-matched divider with a fabric-side clock source
`timescale 1ns/100ps
module lpmd_phase_matched_divider_tb;
  logic ref_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic div_rst = 1'b1;
  logic divided_output_release = 1'b0;
  logic run = 1'b0;
  logic mon = 1'b0;
  logic started = 1'b0;
  logic trk = 1'b0;
  logic g_seen = 1'b0;
  logic ca, cb, pass, half, quar, eig, fb, pass_d;
  logic [4:0] off_q;
  logic [4:0] g_q;
  logic [2:0] a_d = 3'h0, b_d = 3'h0, k = 3'h0;
  int err_total = 0;
  int n_compared = 0;
  always #5 ref_clk_in = ~ref_clk_in;
  lpmd_fabric_model fab (.ref_clk_in(ref_clk_in), .run_in(run), .clk_a_out(ca), .clk_b_out(cb));
  lpmd_phase_matched_divider #(.divider_mode_select(1'b1)) dut (.ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in), .primary_clock_input_in(ca), .feedback_clock_input_in(cb),
    .divider_reset_in(div_rst), .divided_output_release_in(divided_output_release), .clock_a_passthrough_out(pass),
    .clock_a_half_out(half), .clock_a_quarter_out(quar), .clock_a_eighth_out(eig),
    .feedback_clock_output_out(fb));
  // Mode left at its default, so this copy must stay silent
  lpmd_phase_matched_divider dut_off (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
    .primary_clock_input_in(ca), .feedback_clock_input_in(cb), .divider_reset_in(div_rst),
    .divided_output_release_in(divided_output_release), .clock_a_passthrough_out(off_q[0]), .clock_a_half_out(off_q[1]),
    .clock_a_quarter_out(off_q[2]), .clock_a_eighth_out(off_q[3]), .feedback_clock_output_out(off_q[4]));
  // Gated copy, released on B; divided outputs wait for the release pin
  lpmd_phase_matched_divider #(.divider_mode_select(1'b1), .release_gate_enable(1'b1),
    .reset_release_clock_select(lpmd_pkg::LPMD_SYNC_CLOCK_B)) dut_gate (.ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in), .primary_clock_input_in(ca), .feedback_clock_input_in(cb),
    .divider_reset_in(div_rst), .divided_output_release_in(divided_output_release), .clock_a_passthrough_out(g_q[0]),
    .clock_a_half_out(g_q[1]), .clock_a_quarter_out(g_q[2]), .clock_a_eighth_out(g_q[3]),
    .feedback_clock_output_out(g_q[4]));
  task automatic check(input logic [2:0] got, input logic [2:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %b want %b", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("Compared %0d, errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge ref_clk_in) begin
    a_d <= {a_d[1:0], ca};
    b_d <= {b_d[1:0], cb};
    pass_d <= pass;
  end
  // Copies lag the inputs by the fixed three-cycle sync path
  always @(negedge ref_clk_in) begin
    if (mon) begin
      check({g_q[4], fb, pass}, {b_d[2], b_d[2], a_d[2]});
    end
    if (g_q[1]) begin
      g_seen = 1'b1;
    end
    // Tracked from release on, so the very first divided step is seen
    if (trk && pass && !pass_d) begin
      if (!started && half) begin
        started = 1'b1;
        k = 3'h0;
      end
      if (started) begin
        check({eig, quar, half}, ~k);
        k = k + 3'h1;
      end
    end
  end
  task automatic run_phase(input logic exp_gate);
    started = 1'b0;
    g_seen = 1'b0;
    @(posedge ref_clk_in);
    #1 div_rst = 1'b0;
    trk = 1'b1;
    @(posedge ref_clk_in);
    #1 check({pass, half, eig}, 3'h0);
    repeat (20) @(posedge ref_clk_in);
    #1 mon = 1'b1;
    repeat (200) @(posedge ref_clk_in);
    #1 mon = 1'b0;
    trk = 1'b0;
    check({2'h0, started}, 3'h1);
    if (exp_gate) begin
      check({2'h0, g_seen}, 3'h1);
    end else begin
      check({2'h0, g_seen}, 3'h0);
    end
    check({off_q[4:3] | off_q[2:1], off_q[0]}, 3'h0);
  endtask
  task automatic async_reset();
    do begin
      @(posedge ref_clk_in);
      #1;
    end while (!(pass && half));
    div_rst = 1'b1;
    divided_output_release = 1'b1;
    #2 check({pass, half, quar}, 3'h0);
    check({eig, fb, 1'b0}, 3'h0);
  endtask
  initial begin
    repeat (12) @(posedge ref_clk_in);
    #1 reset_n_in = 1'b1;
    run = 1'b1;
    repeat (5) @(posedge ref_clk_in);
    run_phase(1'b0);
    async_reset();
    run_phase(1'b1);
    finish_test();
  end
  initial begin
    #50000 err_total++;
    finish_test();
  end
endmodule
